// File: host_port_model.sv
`timescale 1ns/1ps
module host_port_model
  import meas_setup_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdi_o
);
  // Each clock phase lasts four cycles, above the two-cycle floor
  localparam int HALF = 4;
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end
  // ------------------------------------------------------------------
  // One command byte and one data byte per select-low period
  // ------------------------------------------------------------------
  task automatic xfer(input logic wr, input reg_addr_t a,
                      input reg_byte_t wd, output reg_byte_t rd);
    logic [15:0] frame;
    frame = {1'b0, wr, a, wd};
    rd = 8'h00;
    @(posedge clk_i);
    sel_n_o <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      sclk_o <= 1'b0;
      sdi_o <= frame[i];
      repeat (HALF) @(posedge clk_i);
      if (i < 8) begin
        rd[i] = sdo_i;
      end
      sclk_o <= 1'b1;
      repeat (HALF) @(posedge clk_i);
    end
    sclk_o <= 1'b0;
    // A released data line must not keep showing its last bit
    sdi_o <= ~frame[0];
    repeat (HALF) @(posedge clk_i);
    sel_n_o <= 1'b1;
    repeat (HALF) @(posedge clk_i);
  endtask
endmodule

// File: meas_setup_defs.svh
`ifndef MEAS_SETUP_DEFS_SVH
`define MEAS_SETUP_DEFS_SVH

// ----------------------------------------------------------------------
// Register offsets (6-bit serial address space)
// ----------------------------------------------------------------------
`define OFS_CHANNEL_MEASUREMENT_CFG   6'h02
`define OFS_TEMPERATURE_THRESHOLD_CFG 6'h03
`define OFS_RECEIVE_TRIGGER_PHASE_CFG 6'h04
`define OFS_GAIN_AMPLIFIER_TIMING_HI  6'h05

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_CHANNEL_MEASUREMENT_CFG   8'h00
`define RST_TEMPERATURE_THRESHOLD_CFG 8'h03
`define RST_RECEIVE_TRIGGER_PHASE_CFG 8'h1f
`define RST_GAIN_AMPLIFIER_TIMING_HI  8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_COMMON_LEVEL_SOURCE     7
`define BIT_MEASUREMENT_TYPE        6
`define BIT_BURST_DAMPING           5
`define BIT_AUTO_PAIR_SWAP          4
`define BIT_PIN_PAIR_SELECT_ENABLE  3
`define BIT_PAIR_SELECT_BIT         2
`define RNG_FLIGHT_TIME_MODE        1:0
`define BIT_TEMP_CHANNEL_SELECT     6
`define BIT_SENSOR_RESISTANCE_TYPE  5
`define BIT_TEMP_DIVIDER_SELECT     4
`define BIT_POWER_BLANKING          3
`define RNG_ECHO_THRESHOLD_CODE     2:0
`define BIT_ECHO_MODE               6
`define BIT_START_EDGE_SELECT       5
`define RNG_BURST_INVERSION_POS     4:0
`define RNG_AMPLIFIER_GAIN_CODE     7:5
`define BIT_GAIN_STAGE_CONTROL      4
`define BIT_LOW_NOISE_STAGE_CONTROL 3
`define BIT_LOW_NOISE_FEEDBACK_SEL  2
`define RNG_TIMING_HIGH             1:0

// ----------------------------------------------------------------------
// Codes and serial framing
// ----------------------------------------------------------------------
`define FLIGHT_MODE_TWO        2'h2
`define FLIGHT_MODE_RESERVED   2'h3
`define ECHO_THRESHOLD_MAX     3'h7
`define CMD_BIT_WRITE          6
`define CMD_RNG_ADDR           5:0
`define SERIAL_LAST_BIT        3'h7

`endif

// File: meas_setup_pkg.sv
package meas_setup_pkg;

  // Serial frame phases, one-hot
  typedef enum logic [3:0] {
    SER_IDLE = 4'b0001,
    SER_CMD  = 4'b0010,
    SER_DATA = 4'b0100,
    SER_DONE = 4'b1000
  } ser_state_t;

  typedef logic [7:0] reg_byte_t;
  typedef logic [5:0] reg_addr_t;

endpackage

// File: measurement_setup_registers.sv
`timescale 1ns/1ps
`include "meas_setup_defs.svh"

module measurement_setup_registers
  import meas_setup_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RESET_I,
  input  wire logic       CE_I,
  input  wire logic       SEL_N_I,
  input  wire logic       SCLK_I,
  input  wire logic       SDI_I,
  output logic            SDO_O,
  output logic            SDO_OE_O,
  input  wire logic       PAIR_SELECT_PIN_I,
  input  wire logic       MEAS_DONE_I,
  input  wire logic       TRIGGER_I,
  input  wire logic       SIGNAL_HIGH_RAW_I,
  output logic            COMMON_LEVEL_SOURCE_O,
  output logic            MEASUREMENT_TYPE_SELECT_O,
  output logic            BURST_DAMPING_O,
  output logic            ACTIVE_PAIR_O,
  output logic [1:0]      FLIGHT_TIME_MODE_O,
  output logic            MODE_RESERVED_O,
  output logic            TEMP_FIRST_ONLY_O,
  output logic            SENSOR_RESISTANCE_TYPE_O,
  output logic            TEMP_USE_TRANSMIT_DIVIDER_O,
  output logic            POWER_BLANKING_O,
  output logic [2:0]      ECHO_THRESHOLD_CODE_O,
  output logic            MULTI_ECHO_O,
  output logic            START_EDGE_SELECT_O,
  output logic [4:0]      BURST_INVERSION_POSITION_O,
  output logic [2:0]      AMPLIFIER_GAIN_CODE_O,
  output logic            GAIN_STAGE_CONTROL_O,
  output logic            LOW_NOISE_STAGE_CONTROL_O,
  output logic            LOW_NOISE_FEEDBACK_SELECT_O,
  output logic [1:0]      TIMING_HIGH_O,
  output logic            START_O,
  output logic            SIGNAL_TOO_HIGH_FLAG_O
);

  // --------------------------------------------------------------------
  // Storage
  // --------------------------------------------------------------------
  reg_byte_t chan_cfg_q;
  reg_byte_t temp_cfg_q;
  reg_byte_t trig_cfg_q;
  reg_byte_t gain_cfg_q;
  logic      swap_q;
  logic      trig_prev_q;
  logic      start_q;
  logic      too_high_q;

  reg_addr_t addr_w;
  reg_byte_t wdata_w;
  logic      wr_stb_w;
  reg_byte_t rdata_w;

  // --------------------------------------------------------------------
  // Serial port
  // --------------------------------------------------------------------
  serial_frame u_serial_frame (
    .clk_i    (CLK_I),
    .rst_i    (RESET_I),
    .ce_i     (CE_I),
    .sel_n_i  (SEL_N_I),
    .sclk_i   (SCLK_I),
    .sdi_i    (SDI_I),
    .rdata_i  (rdata_w),
    .addr_o   (addr_w),
    .wdata_o  (wdata_w),
    .wr_stb_o (wr_stb_w),
    .sdo_o    (SDO_O),
    .sdo_oe_o (SDO_OE_O)
  );

  // --------------------------------------------------------------------
  // Address decode
  // --------------------------------------------------------------------
  wire hit_chan_w = (addr_w == `OFS_CHANNEL_MEASUREMENT_CFG);
  wire hit_temp_w = (addr_w == `OFS_TEMPERATURE_THRESHOLD_CFG);
  wire hit_trig_w = (addr_w == `OFS_RECEIVE_TRIGGER_PHASE_CFG);
  wire hit_gain_w = (addr_w == `OFS_GAIN_AMPLIFIER_TIMING_HI);

  wire wr_chan_w = wr_stb_w & hit_chan_w;
  wire wr_temp_w = wr_stb_w & hit_temp_w;
  wire wr_trig_w = wr_stb_w & hit_trig_w;
  wire wr_gain_w = wr_stb_w & hit_gain_w;

  // Addresses outside this bank read as zero and ignore writes
  always_comb begin
    if (hit_chan_w) begin
      rdata_w = chan_cfg_q;
    end else if (hit_temp_w) begin
      rdata_w = temp_cfg_q;
    end else if (hit_trig_w) begin
      rdata_w = trig_cfg_q;
    end else if (hit_gain_w) begin
      rdata_w = gain_cfg_q;
    end else begin
      rdata_w = 8'h00;
    end
  end

  // --------------------------------------------------------------------
  // Register writes
  // --------------------------------------------------------------------
  // Reserved bits are stored as written; the host keeps them zero
  // One short process per register keeps each write path apart
  // Writes wait for the enable like every other state bit
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      chan_cfg_q <= `RST_CHANNEL_MEASUREMENT_CFG;
    end else if (CE_I && wr_chan_w) begin
      chan_cfg_q <= wdata_w;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      temp_cfg_q <= `RST_TEMPERATURE_THRESHOLD_CFG;
    end else if (CE_I && wr_temp_w) begin
      temp_cfg_q <= wdata_w;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trig_cfg_q <= `RST_RECEIVE_TRIGGER_PHASE_CFG;
    end else if (CE_I && wr_trig_w) begin
      trig_cfg_q <= wdata_w;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      gain_cfg_q <= `RST_GAIN_AMPLIFIER_TIMING_HI;
    end else if (CE_I && wr_gain_w) begin
      gain_cfg_q <= wdata_w;
    end
  end

  // --------------------------------------------------------------------
  // Channel and measurement selection
  // --------------------------------------------------------------------
  wire       pin_sel_en_w  = chan_cfg_q[`BIT_PIN_PAIR_SELECT_ENABLE];
  wire       pair_bit_w    = chan_cfg_q[`BIT_PAIR_SELECT_BIT];
  wire       auto_swap_w   = chan_cfg_q[`BIT_AUTO_PAIR_SWAP];
  wire [1:0] mode_code_w   = chan_cfg_q[`RNG_FLIGHT_TIME_MODE];
  wire       mode_rsvd_w   = (mode_code_w == `FLIGHT_MODE_RESERVED);
  wire       mode_two_w    = (mode_code_w == `FLIGHT_MODE_TWO);

  // Swap only runs in mode 2 and is dead under pin selection
  wire       swap_active_w = auto_swap_w & mode_two_w & ~pin_sel_en_w;

  // Pin wins over the swap and the select bit
  wire       active_pair_w = pin_sel_en_w ? PAIR_SELECT_PIN_I :
                             (pair_bit_w ^ (swap_active_w & swap_q));

  // The reserved code falls back to mode 0 so the core never sees it
  wire [1:0] mode_eff_w    = mode_rsvd_w ? 2'h0 : mode_code_w;

  // Swap phase alternates after each finished measurement
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      swap_q <= 1'b0;
    end else if (CE_I) begin
      if (!swap_active_w) begin
        swap_q <= 1'b0;
      end else if (MEAS_DONE_I) begin
        swap_q <= ~swap_q;
      end
    end
  end

  // --------------------------------------------------------------------
  // Trigger edge and error qualification
  // --------------------------------------------------------------------
  wire edge_sel_w   = trig_cfg_q[`BIT_START_EDGE_SELECT];
  wire rise_w       = TRIGGER_I & ~trig_prev_q;
  wire fall_w       = ~TRIGGER_I & trig_prev_q;
  wire start_w      = edge_sel_w ? fall_w : rise_w;
  wire [2:0] thr_w  = temp_cfg_q[`RNG_ECHO_THRESHOLD_CODE];
  wire thr_max_w    = (thr_w == `ECHO_THRESHOLD_MAX);

  // Edge history freezes with the enable; a change while frozen
  // is seen as an edge on resume
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      trig_prev_q <= 1'b0;
    end else if (CE_I) begin
      trig_prev_q <= TRIGGER_I;
    end
  end

  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      start_q <= 1'b0;
    end else if (CE_I) begin
      start_q <= start_w;
    end
  end

  // Gated, not sticky: the flag follows the raw level one cycle late
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      too_high_q <= 1'b0;
    end else if (CE_I) begin
      too_high_q <= SIGNAL_HIGH_RAW_I & thr_max_w;
    end
  end

  // --------------------------------------------------------------------
  // Field outputs: channel and measurement
  // --------------------------------------------------------------------
  // Code 3 reads back as written but drives mode 0
  assign COMMON_LEVEL_SOURCE_O =
    chan_cfg_q[`BIT_COMMON_LEVEL_SOURCE];
  assign MEASUREMENT_TYPE_SELECT_O =
    chan_cfg_q[`BIT_MEASUREMENT_TYPE];
  assign BURST_DAMPING_O =
    chan_cfg_q[`BIT_BURST_DAMPING];
  assign ACTIVE_PAIR_O =
    active_pair_w;
  assign FLIGHT_TIME_MODE_O =
    mode_eff_w;
  assign MODE_RESERVED_O =
    mode_rsvd_w;

  // --------------------------------------------------------------------
  // Field outputs: temperature and threshold
  // --------------------------------------------------------------------
  // Blanking length comes from the timing field of the gain register
  assign TEMP_FIRST_ONLY_O =
    temp_cfg_q[`BIT_TEMP_CHANNEL_SELECT];
  assign SENSOR_RESISTANCE_TYPE_O =
    temp_cfg_q[`BIT_SENSOR_RESISTANCE_TYPE];
  assign TEMP_USE_TRANSMIT_DIVIDER_O =
    temp_cfg_q[`BIT_TEMP_DIVIDER_SELECT];
  assign POWER_BLANKING_O =
    temp_cfg_q[`BIT_POWER_BLANKING];
  assign ECHO_THRESHOLD_CODE_O =
    thr_w;

  // --------------------------------------------------------------------
  // Field outputs: receive, trigger and burst phase
  // --------------------------------------------------------------------
  assign MULTI_ECHO_O =
    trig_cfg_q[`BIT_ECHO_MODE];
  assign START_EDGE_SELECT_O =
    edge_sel_w;
  // Positions 0 and 1 are passed through; the host avoids them
  assign BURST_INVERSION_POSITION_O =
    trig_cfg_q[`RNG_BURST_INVERSION_POS];
  // Start lasts one clock, so the core must look every cycle
  assign START_O =
    start_q;

  // --------------------------------------------------------------------
  // Field outputs: gain, amplifier and timing high bits
  // --------------------------------------------------------------------
  // Amplifier controls pass straight to the analog stages
  assign AMPLIFIER_GAIN_CODE_O =
    gain_cfg_q[`RNG_AMPLIFIER_GAIN_CODE];
  assign GAIN_STAGE_CONTROL_O =
    gain_cfg_q[`BIT_GAIN_STAGE_CONTROL];
  assign LOW_NOISE_STAGE_CONTROL_O =
    gain_cfg_q[`BIT_LOW_NOISE_STAGE_CONTROL];
  assign LOW_NOISE_FEEDBACK_SELECT_O =
    gain_cfg_q[`BIT_LOW_NOISE_FEEDBACK_SEL];
  assign TIMING_HIGH_O =
    gain_cfg_q[`RNG_TIMING_HIGH];

  // --------------------------------------------------------------------
  // Status
  // --------------------------------------------------------------------
  // Only gated here; clearing and reporting live outside this bank
  assign SIGNAL_TOO_HIGH_FLAG_O =
    too_high_q;

endmodule

// File: measurement_setup_registers_monitor.sv
`timescale 1ns/1ps
module setup_register_monitor (
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  input wire logic       CE_I,
  input wire logic       SEL_N_I,
  input wire logic       TRIGGER_I,
  input wire logic       SIGNAL_HIGH_RAW_I,
  input wire logic       SDO_OE_O,
  input wire logic       COMMON_LEVEL_SOURCE_O,
  input wire logic [1:0] FLIGHT_TIME_MODE_O,
  input wire logic       MODE_RESERVED_O,
  input wire logic [2:0] ECHO_THRESHOLD_CODE_O,
  input wire logic       START_EDGE_SELECT_O,
  input wire logic [4:0] BURST_INVERSION_POSITION_O,
  input wire logic [2:0] AMPLIFIER_GAIN_CODE_O,
  input wire logic [1:0] TIMING_HIGH_O,
  input wire logic       START_O,
  input wire logic       SIGNAL_TOO_HIGH_FLAG_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);

  // ------------------------------------------------------------------
  // Register defaults and field behaviour
  // ------------------------------------------------------------------
  reset_defaults_a: assert property ($fell(RESET_I) |->
    ECHO_THRESHOLD_CODE_O == 3'h3 && BURST_INVERSION_POSITION_O == 5'h1f
    && AMPLIFIER_GAIN_CODE_O == 3'h0 && TIMING_HIGH_O == 2'h0)
    else $error("config outputs not at defaults after reset");
  reserved_mode_a: assert property (MODE_RESERVED_O |->
    FLIGHT_TIME_MODE_O == 2'h0) else $error("reserved mode leaks out");
  flag_set_a: assert property (CE_I && SIGNAL_HIGH_RAW_I &&
    ECHO_THRESHOLD_CODE_O == 3'h7 |=> SIGNAL_TOO_HIGH_FLAG_O)
    else $error("signal high flag missing");
  // A flag held while the enable was low is not judged; only one set in the cycle before is
  flag_gate_a: assert property ($past(CE_I) &&
    SIGNAL_TOO_HIGH_FLAG_O |-> $past(ECHO_THRESHOLD_CODE_O) == 3'h7
    && $past(SIGNAL_HIGH_RAW_I))
    else $error("signal high flag below top threshold");
  rise_start_a: assert property (CE_I && $past(CE_I) &&
    $rose(TRIGGER_I) && !START_EDGE_SELECT_O |=> START_O)
    else $error("no start on rising trigger");
  fall_start_a: assert property (CE_I && $past(CE_I) &&
    $fell(TRIGGER_I) && START_EDGE_SELECT_O |=> START_O)
    else $error("no start on falling trigger");
  start_cause_a: assert property (START_O |->
    $past(TRIGGER_I) != $past(START_EDGE_SELECT_O))
    else $error("start on the wrong trigger edge");
  oe_select_a: assert property (SDO_OE_O |-> !$past(SEL_N_I))
    else $error("data out driven while deselected");
  // Writes land two cycles after the frame, so three idle cycles suffice
  config_hold_a: assert property ($past(SEL_N_I) &&
    $past(SEL_N_I, 2) && $past(SEL_N_I, 3) |-> $stable({
    COMMON_LEVEL_SOURCE_O, FLIGHT_TIME_MODE_O, ECHO_THRESHOLD_CODE_O,
    BURST_INVERSION_POSITION_O, AMPLIFIER_GAIN_CODE_O, TIMING_HIGH_O}))
    else $error("config changed without a frame");

  start_c: cover property (START_O);
  flag_c: cover property (SIGNAL_TOO_HIGH_FLAG_O);
  read_c: cover property (SDO_OE_O);
  mode_c: cover property (MODE_RESERVED_O);
endmodule

bind measurement_setup_registers setup_register_monitor i_mon (
  .CLK_I(CLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .SEL_N_I(SEL_N_I),
  .TRIGGER_I(TRIGGER_I), .SIGNAL_HIGH_RAW_I(SIGNAL_HIGH_RAW_I),
  .SDO_OE_O(SDO_OE_O), .COMMON_LEVEL_SOURCE_O(COMMON_LEVEL_SOURCE_O),
  .FLIGHT_TIME_MODE_O(FLIGHT_TIME_MODE_O), .MODE_RESERVED_O(MODE_RESERVED_O),
  .ECHO_THRESHOLD_CODE_O(ECHO_THRESHOLD_CODE_O),
  .START_EDGE_SELECT_O(START_EDGE_SELECT_O),
  .BURST_INVERSION_POSITION_O(BURST_INVERSION_POSITION_O),
  .AMPLIFIER_GAIN_CODE_O(AMPLIFIER_GAIN_CODE_O),
  .TIMING_HIGH_O(TIMING_HIGH_O), .START_O(START_O),
  .SIGNAL_TOO_HIGH_FLAG_O(SIGNAL_TOO_HIGH_FLAG_O));

// File: serial_frame.sv
`timescale 1ns/1ps
`include "meas_setup_defs.svh"

module serial_frame
  import meas_setup_pkg::*;
(
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  input  wire logic      ce_i,
  input  wire logic      sel_n_i,
  input  wire logic      sclk_i,
  input  wire logic      sdi_i,
  input  wire reg_byte_t rdata_i,
  output reg_addr_t      addr_o,
  output reg_byte_t      wdata_o,
  output logic           wr_stb_o,
  output logic           sdo_o,
  output logic           sdo_oe_o
);

  ser_state_t state_q;
  ser_state_t state_d;
  logic       sclk_prev_q;
  logic [2:0] cnt_q;
  reg_byte_t  in_q;
  reg_byte_t  out_q;
  logic       write_q;
  logic       wr_stb_q;

  wire        rise_w    = sclk_i & ~sclk_prev_q;
  wire        fall_w    = ~sclk_i & sclk_prev_q;
  wire        last_w    = (cnt_q == `SERIAL_LAST_BIT);
  wire        take_w    = rise_w & ~sel_n_i;
  wire        cmd_end_w = take_w & last_w & (state_q == SER_CMD);
  wire        dat_end_w = take_w & last_w & (state_q == SER_DATA);
  wire reg_byte_t shifted_w = {in_q[6:0], sdi_i};

  // --------------------------------------------------------------------
  // Frame sequencing: a raised select always abandons the frame
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      SER_IDLE: if (!sel_n_i) state_d = SER_CMD;
      SER_CMD:  if (cmd_end_w) state_d = SER_DATA;
      SER_DATA: if (dat_end_w) state_d = SER_DONE;
      SER_DONE: state_d = SER_DONE;
      default:  state_d = SER_IDLE;
    endcase
    if (sel_n_i) state_d = SER_IDLE;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q     <= SER_IDLE;
      sclk_prev_q <= 1'b0;
      cnt_q       <= 3'h0;
      in_q        <= 8'h00;
      out_q       <= 8'h00;
      write_q     <= 1'b0;
      wr_stb_q    <= 1'b0;
      addr_o      <= 6'h00;
      wdata_o     <= 8'h00;
    end else if (ce_i) begin
      state_q     <= state_d;
      sclk_prev_q <= sclk_i;
      wr_stb_q    <= dat_end_w & write_q;
      if (sel_n_i) begin
        cnt_q <= 3'h0;
      end else if (take_w) begin
        cnt_q <= cnt_q + 3'h1;
        in_q  <= shifted_w;
      end
      if (cmd_end_w) begin
        write_q <= shifted_w[`CMD_BIT_WRITE];
        addr_o  <= shifted_w[`CMD_RNG_ADDR];
      end
      if (dat_end_w) wdata_o <= shifted_w;
      // Read data is loaded one cycle after the address settles
      if (state_q == SER_DATA && cnt_q == 3'h0 && !fall_w && !rise_w)
        out_q <= rdata_i;
      else if (fall_w && state_q == SER_DATA && cnt_q != 3'h0)
        out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign wr_stb_o = wr_stb_q;
  assign sdo_o    = out_q[7];
  assign sdo_oe_o = ~sel_n_i & ~write_q & (state_q == SER_DATA);

endmodule

// File: test_measurement_setup_registers.sv
`timescale 1ns/1ps
module test_measurement_setup_registers
  import meas_setup_pkg::*;
;
  logic       clk, rst, pin, done, trig, raw, sel_n, sclk, sdi, sdo, oe, ce;
  logic       common, mtype, damp, pair, mres, tfirst, rtype, tdiv, blank;
  logic       multi, edge_sel, gstage, lnstage, lnfb, start, flag;
  logic [1:0] fmode, thi;
  logic [2:0] thr, gain;
  logic [4:0] inv_pos;
  int         errors, checks;
  reg_byte_t  rd;
  // An undriven data line reads inverted, so a missing enable shows
  wire        sdo_line = oe ? sdo : ~sdo;

  measurement_setup_registers i_dut (
    .CLK_I(clk), .RESET_I(rst), .CE_I(ce), .SEL_N_I(sel_n),
    .SCLK_I(sclk), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(oe),
    .PAIR_SELECT_PIN_I(pin), .MEAS_DONE_I(done), .TRIGGER_I(trig),
    .SIGNAL_HIGH_RAW_I(raw), .COMMON_LEVEL_SOURCE_O(common),
    .MEASUREMENT_TYPE_SELECT_O(mtype), .BURST_DAMPING_O(damp),
    .ACTIVE_PAIR_O(pair), .FLIGHT_TIME_MODE_O(fmode),
    .MODE_RESERVED_O(mres), .TEMP_FIRST_ONLY_O(tfirst),
    .SENSOR_RESISTANCE_TYPE_O(rtype), .TEMP_USE_TRANSMIT_DIVIDER_O(tdiv),
    .POWER_BLANKING_O(blank), .ECHO_THRESHOLD_CODE_O(thr),
    .MULTI_ECHO_O(multi), .START_EDGE_SELECT_O(edge_sel),
    .BURST_INVERSION_POSITION_O(inv_pos), .AMPLIFIER_GAIN_CODE_O(gain),
    .GAIN_STAGE_CONTROL_O(gstage), .LOW_NOISE_STAGE_CONTROL_O(lnstage),
    .LOW_NOISE_FEEDBACK_SELECT_O(lnfb), .TIMING_HIGH_O(thi),
    .START_O(start), .SIGNAL_TOO_HIGH_FLAG_O(flag));
  host_port_model i_host (.clk_i(clk), .sdo_i(sdo_line), .sel_n_o(sel_n),
                          .sclk_o(sclk), .sdi_o(sdi));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ------------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t mismatch seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    i_host.xfer(1'b1, a, d, rd);
    @(negedge clk);
  endtask
  task automatic rd_chk(input reg_addr_t a, input reg_byte_t exp);
    i_host.xfer(1'b0, a, 8'h00, rd);
    check(rd, exp);
  endtask
  task automatic pulse_done();
    @(posedge clk) done <= 1'b1;
    @(posedge clk) done <= 1'b0;
    @(negedge clk);
  endtask
  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  task automatic t_reset();
    reg_byte_t dflt [4] = '{8'h00, 8'h03, 8'h1f, 8'h00};
    @(negedge clk);
    check({common, mtype, damp, pair, fmode, mres, tfirst}, 8'h00);
    check(oe, 1'b0);
    check({thr, inv_pos}, {3'h3, 5'h1f});
    check({gain, gstage, lnstage, lnfb, thi}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      rd_chk(6'(i + 2), dflt[i]);
    end
  endtask
  task automatic t_fields();
    wr(6'h02, 8'he4);
    check({1'b0, common, mtype, damp, pair, fmode, mres}, 8'h78);
    for (int m = 0; m < 4; m++) begin
      wr(6'h02, 8'(m));
      check({fmode, mres}, (m == 3) ? 8'h01 : 8'(m * 2));
      rd_chk(6'h02, 8'(m));
    end
    wr(6'h03, 8'h7f);
    check({1'b0, tfirst, rtype, tdiv, blank, thr}, 8'h7f);
    rd_chk(6'h03, 8'h7f);
    wr(6'h04, 8'h42);
    check({1'b0, multi, edge_sel, inv_pos}, 8'h42);
    wr(6'h05, 8'h56);
    check({gain, gstage, lnstage, lnfb, thi}, 8'h56);
    wr(6'h05, 8'ha9);
    check({gain, gstage, lnstage, lnfb, thi}, 8'ha9);
    wr(6'h3f, 8'h5a);
    rd_chk(6'h3f, 8'h00);
    rd_chk(6'h05, 8'ha9);
  endtask
  task automatic t_pair();
    wr(6'h02, 8'h0c);
    check(pair, 1'b0);
    @(posedge clk) pin <= 1'b1;
    @(negedge clk);
    check(pair, 1'b1);
    wr(6'h02, 8'h1a);
    pulse_done();
    check(pair, 1'b1);
    wr(6'h02, 8'h12);
    check(pair, 1'b0);
    pulse_done();
    check(pair, 1'b1);
    pulse_done();
    check(pair, 1'b0);
    wr(6'h02, 8'h11);
    pulse_done();
    check(pair, 1'b0);
  endtask
  task automatic t_trigger();
    int n;
    for (int s = 0; s < 2; s++) begin
      wr(6'h04, {2'b00, 1'(s), 5'h02});
      for (int v = 1; v >= 0; v--) begin
        n = 0;
        @(posedge clk) trig <= 1'(v);
        repeat (4) @(negedge clk) n += (start === 1'b1);
        check(8'(n), 8'(v != s));
      end
    end
  endtask
  task automatic t_flag();
    wr(6'h03, 8'h03);
    @(posedge clk) raw <= 1'b1;
    repeat (2) @(negedge clk);
    check(flag, 1'b0);
    wr(6'h03, 8'h07);
    check(flag, 1'b1);
    @(posedge clk) begin
      ce  <= 1'b0;
      raw <= 1'b0;
    end
    repeat (3) @(negedge clk);
    check(flag, 1'b1);
    @(posedge clk) ce <= 1'b1;
    repeat (2) @(negedge clk);
    check(flag, 1'b0);
    @(posedge clk) raw <= 1'b0;
    repeat (2) @(negedge clk);
    check(flag, 1'b0);
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("ERROR %0t run did not finish", $time);
    conclude();
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    pin = 1'b0;
    done = 1'b0;
    trig = 1'b0;
    raw = 1'b0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_fields();
    t_pair();
    t_trigger();
    t_flag();
    @(posedge clk) rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    conclude();
  end
endmodule
